// >>> t1cic_timer.v
// Purpose: Compare, flag, PLL clock control and prescaler of an 8-bit fast timer
// Assumes: fastClkTick is a one-cycle pulse per fast peripheral clock edge on sys_clk
// Notes:   Registers reached over AXI4-Lite; flags raise irq lines toward the core
// Functional notes
// - Match only when counter advances into a compare value, checked on every count.
// - Software writes that make counter equal a compare value never match.
// - A or B match sets its flag one cycle after the match.
// - With clear-on-top set, a top match clears the counter.
// - Mask bit 6 with global enable and A flag requests A interrupt.
// - Mask bit 5 with global enable and B flag requests B interrupt.
// - Mask bit 2 with global enable and overflow flag requests overflow interrupt.
// - Bits 7 and 0 of mask and flag registers read zero.
// - Flags clear on vector execution, or one cycle after writing one.
// - Normal mode sets overflow flag on counter wraparound.
// - PWM mode sets overflow flag on top match instead of wraparound.
// - Low-speed bit 7 defaults zero; set halves the fast clock outside compatibility mode.
// - Low-speed bit cannot be set while PLL is the system clock.
// - Bit 2 selects fast clock asynchronous or system clock synchronous timing.
// - Fast-clock select accepted only with PLL enabled; software waits for lock.
// - PLL enable bit 1 starts PLL; reads one when PLL is system clock.
// - Lock bit 0 reports lock, hidden until the 100 us settle time.
// - PLL register bits 6 to 3 read zero.
// - Compatibility mode: 10-bit system and 3-bit fast prescalers, always synchronous.
// - Compatibility offers fast/1,2,4,8, system/1 to 1024, or stop.
// - In PWM or clear-on-top, counter returns to zero the cycle after top match.
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`include "t1cic_consts.vh"

module t1cic_timer #(
	parameter SETTLE_CYCLES = `T1CIC_SETTLE_CYC
) (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rstn,
	// AXI4-Lite write address and data
	input  wire [5:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read
	input  wire [5:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Core interface
	input  wire        globalIrqEnable,
	input  wire        vecDoneCmpA,
	input  wire        vecDoneCmpB,
	input  wire        vecDoneOvf,
	output reg         irqCmpA,
	output reg         irqCmpB,
	output reg         irqOvf,
	// Clock system
	input  wire        fastClkTick,
	input  wire        pllLockPin,
	input  wire        pllIsSysClkPin,
	input  wire [3:0]  clockSelectFusesPin,
	output wire        pllEnableOut,
	output wire        lowSpeedOut,
	// Match events
	output reg         matchA,
	output reg         matchB,
	output reg         matchTop
);

	// Decoded prescaler choice: {useFast, stop, shift[3:0]}
	function [5:0] presc_decode;
		input [3:0] cs;
		input       compat;
		begin
			if (cs == 4'h0)
				presc_decode = 6'h10;
			else if (!compat)
				presc_decode = {2'b00, cs - 4'h1};
			else if (cs <= `T1CIC_COMPAT_FAST_MAX)
				presc_decode = {2'b10, cs - 4'h1};
			else
				presc_decode = {2'b00, cs - 4'h5};
		end
	endfunction

	function [`T1CIC_PRE_W-1:0] low_mask;
		input [3:0] shift;
		integer i;
		begin
			low_mask = {`T1CIC_PRE_W{1'b0}};
			for (i = 0; i < `T1CIC_PRE_W; i = i + 1)
				if (i < shift)
					low_mask[i] = 1'b1;
		end
	endfunction

	// Pin synchronisers
	reg  [5:0]  pinMeta_reg;
	reg  [5:0]  pinSync_reg;

	always @(posedge sys_clk) begin
		if (!rstn) begin
			pinMeta_reg <= 6'h00;
			pinSync_reg <= 6'h00;
		end else begin
			pinMeta_reg <= {clockSelectFusesPin, pllIsSysClkPin, pllLockPin};
			pinSync_reg <= pinMeta_reg;
		end
	end

	wire        lockSync   = pinSync_reg[0];
	wire        pllIsSys   = pinSync_reg[1];
	wire [3:0]  fuses      = pinSync_reg[5:2];
	wire        compatMode = (fuses == `T1CIC_COMPAT_CODE);

	// Software registers
	reg  [7:0]  count_reg;
	reg  [7:0]  cmpA_reg;
	reg  [7:0]  cmpB_reg;
	reg  [7:0]  top_reg;
	reg  [7:0]  mask_reg;
	reg  [7:0]  flags_reg;
	reg         clrTop_reg;
	reg         pwmA_reg;
	reg         pwmB_reg;
	reg  [3:0]  clkSel_reg;
	reg         lowSpeed_reg;
	reg         fastSel_reg;
	reg         pllEn_reg;

	// AXI write path: address and data may arrive in either order
	reg  [5:0]  awAddr_reg;
	reg         awHeld_reg;
	reg  [31:0] wData_reg;
	reg  [3:0]  wStrb_reg;
	reg         wHeld_reg;

	assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld_reg && !s_axi_bvalid;

	wire        awFire  = s_axi_awvalid && s_axi_awready;
	wire        wFire   = s_axi_wvalid && s_axi_wready;
	wire        awHave  = awHeld_reg || awFire;
	wire        wHave   = wHeld_reg || wFire;
	wire [5:0]  wrAddr  = awHeld_reg ? awAddr_reg : s_axi_awaddr;
	wire [31:0] wrData  = wHeld_reg ? wData_reg : s_axi_wdata;
	wire [3:0]  wrStrb  = wHeld_reg ? wStrb_reg : s_axi_wstrb;
	wire        wrDo    = awHave && wHave;
	wire        wrLane  = wrDo && wrStrb[0];
	wire [7:0]  wrByte  = wrData[7:0];
	wire        wrHit   = (wrAddr[1:0] == 2'b00) && (wrAddr <= `T1CIC_OFS_PLL);

	always @(posedge sys_clk) begin
		if (!rstn) begin
			awHeld_reg   <= 1'b0;
			wHeld_reg    <= 1'b0;
			awAddr_reg   <= 6'h00;
			wData_reg    <= 32'h00000000;
			wStrb_reg    <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `T1CIC_RESP_OKAY;
		end else begin
			if (awFire) begin
				awAddr_reg <= s_axi_awaddr;
			end
			if (wFire) begin
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			if (wrDo) begin
				awHeld_reg   <= 1'b0;
				wHeld_reg    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrHit ? `T1CIC_RESP_OKAY : `T1CIC_RESP_SLVERR;
			end else begin
				awHeld_reg <= awHave;
				wHeld_reg  <= wHave;
				if (s_axi_bvalid && s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
				end
			end
		end
	end

	wire wrCount = wrLane && (wrAddr == `T1CIC_OFS_COUNT);
	wire wrFlags = wrLane && (wrAddr == `T1CIC_OFS_FLAGS);
	wire wrGctrl = wrLane && (wrAddr == `T1CIC_OFS_GCTRL);
	wire wrPll   = wrLane && (wrAddr == `T1CIC_OFS_PLL);

	// PLL control and settle timer
	reg  [12:0] settle_reg;
	wire        settleDone = (settle_reg >= SETTLE_CYCLES[12:0]);

	always @(posedge sys_clk) begin
		if (!rstn) begin
			lowSpeed_reg <= 1'b0;
			fastSel_reg  <= 1'b0;
			pllEn_reg    <= 1'b0;
			settle_reg   <= 13'h0000;
		end else begin
			if (wrPll) begin
				lowSpeed_reg <= wrByte[`T1CIC_PLL_LSM] && !pllIsSys;
				fastSel_reg  <= wrByte[`T1CIC_PLL_FAST_SEL] && pllEnableOut;
				pllEn_reg    <= wrByte[`T1CIC_PLL_EN];
			end
			if (!pllEnableOut)
				settle_reg <= 13'h0000;
			else if (!settleDone)
				settle_reg <= settle_reg + 13'h0001;
		end
	end

	assign pllEnableOut = pllEn_reg || pllIsSys;
	assign lowSpeedOut  = lowSpeed_reg;
	wire   pllLocked    = pllEnableOut && settleDone && lockSync;

	// Low-speed mode passes every other fast tick, except in compat mode
	reg         halfPhase_reg;
	always @(posedge sys_clk) begin
		if (!rstn)
			halfPhase_reg <= 1'b0;
		else if (fastClkTick)
			halfPhase_reg <= !halfPhase_reg;
	end
	wire fastTick = fastClkTick && (!lowSpeed_reg || halfPhase_reg || compatMode);

	// Prescaler and timer tick
	wire [5:0]  presc    = presc_decode(clkSel_reg, compatMode);
	wire        preStop  = presc[4];
	// Compat mode keeps the fast path on sys_clk logic, so it stays synchronous
	wire        useFast  = compatMode ? presc[5] : fastSel_reg;
	wire [3:0]  preShift = (compatMode && presc[5]) ? {2'b00, presc[1:0]} : presc[3:0];
	wire [`T1CIC_PRE_W-1:0] preMask = low_mask(preShift);
	wire        srcTick  = useFast ? fastTick : 1'b1;
	reg  [`T1CIC_PRE_W-1:0] pre_reg;
	wire        timerTick = !preStop && srcTick && ((pre_reg & preMask) == preMask);

	always @(posedge sys_clk) begin
		if (!rstn)
			pre_reg <= {`T1CIC_PRE_W{1'b0}};
		else if (wrGctrl && wrByte[`T1CIC_GCTRL_PRE_RST])
			pre_reg <= {`T1CIC_PRE_W{1'b0}};
		else if (!preStop && srcTick)
			pre_reg <= pre_reg + {{(`T1CIC_PRE_W-1){1'b0}}, 1'b1};
	end

	// Counter, matches and overflow events
	wire        pwmMode   = pwmA_reg || pwmB_reg;
	wire        clrMode   = pwmMode || clrTop_reg;
	wire [7:0]  countInc  = count_reg + 8'h01;
	reg         clearPend_reg;
	reg         ovfEvt_reg;

	always @(posedge sys_clk) begin
		if (!rstn) begin
			count_reg     <= 8'h00;
			clearPend_reg <= 1'b0;
			matchA        <= 1'b0;
			matchB        <= 1'b0;
			matchTop      <= 1'b0;
			ovfEvt_reg    <= 1'b0;
		end else begin
			// Only counting steps are compared, never software loads
			matchA        <= timerTick && !clearPend_reg && (countInc == cmpA_reg);
			matchB        <= timerTick && !clearPend_reg && (countInc == cmpB_reg);
			matchTop      <= timerTick && !clearPend_reg && (countInc == top_reg);
			ovfEvt_reg    <= 1'b0;
			clearPend_reg <= 1'b0;
			if (wrCount) begin
				count_reg <= wrByte;
			end else if (clearPend_reg) begin
				count_reg <= 8'h00;
				ovfEvt_reg <= pwmMode;
			end else if (timerTick) begin
				count_reg     <= countInc;
				clearPend_reg <= clrMode && (countInc == top_reg);
				ovfEvt_reg    <= !pwmMode && (count_reg == 8'hFF);
			end
		end
	end

	// Flags: events pass one register stage; write-one clears wait a cycle
	reg  [7:0]  w1cPend_reg;
	wire [7:0]  setVec = {1'b0, matchA, matchB, 2'b00, ovfEvt_reg, 2'b00};
	wire [7:0]  vecClr = {1'b0, vecDoneCmpA, vecDoneCmpB, 2'b00, vecDoneOvf, 2'b00};

	always @(posedge sys_clk) begin
		if (!rstn) begin
			flags_reg   <= 8'h00;
			w1cPend_reg <= 8'h00;
		end else begin
			w1cPend_reg <= wrFlags ? (wrByte & `T1CIC_IRQ_MASK_BITS) : 8'h00;
			// Set wins over any clear in the same cycle
			flags_reg   <= ((flags_reg & ~(w1cPend_reg | vecClr)) | setVec)
				& `T1CIC_IRQ_MASK_BITS;
		end
	end

	// Remaining software registers
	always @(posedge sys_clk) begin
		if (!rstn) begin
			cmpA_reg   <= 8'h00;
			cmpB_reg   <= 8'h00;
			top_reg    <= 8'hFF;
			mask_reg   <= 8'h00;
			clrTop_reg <= 1'b0;
			pwmA_reg   <= 1'b0;
			pwmB_reg   <= 1'b0;
			clkSel_reg <= 4'h0;
		end else if (wrLane) begin
			case (wrAddr)
				`T1CIC_OFS_CTRL: begin
					clrTop_reg <= wrByte[`T1CIC_CTRL_CLR_TOP];
					pwmA_reg   <= wrByte[`T1CIC_CTRL_PWM_A];
					clkSel_reg <= wrByte[3:0];
				end
				`T1CIC_OFS_GCTRL: pwmB_reg <= wrByte[`T1CIC_GCTRL_PWM_B];
				`T1CIC_OFS_CMPA:  cmpA_reg <= wrByte;
				`T1CIC_OFS_CMPB:  cmpB_reg <= wrByte;
				`T1CIC_OFS_TOP:   top_reg <= wrByte;
				`T1CIC_OFS_MASK:  mask_reg <= wrByte & `T1CIC_IRQ_MASK_BITS;
				default: ;
			endcase
		end
	end

	// Interrupt requests toward the core
	always @(posedge sys_clk) begin
		if (!rstn) begin
			irqCmpA <= 1'b0;
			irqCmpB <= 1'b0;
			irqOvf  <= 1'b0;
		end else begin
			irqCmpA <= globalIrqEnable && mask_reg[`T1CIC_BIT_CMPA] && flags_reg[`T1CIC_BIT_CMPA];
			irqCmpB <= globalIrqEnable && mask_reg[`T1CIC_BIT_CMPB] && flags_reg[`T1CIC_BIT_CMPB];
			irqOvf  <= globalIrqEnable && mask_reg[`T1CIC_BIT_OVF] && flags_reg[`T1CIC_BIT_OVF];
		end
	end

	// AXI read path, one cycle to the answer
	assign s_axi_arready = !s_axi_rvalid;
	reg  [7:0]  rdByte;
	reg         rdHit;

	always @* begin
		rdByte = 8'h00;
		rdHit  = 1'b1;
		case (s_axi_araddr)
			`T1CIC_OFS_COUNT: rdByte = count_reg;
			`T1CIC_OFS_CTRL:  rdByte = {clrTop_reg, pwmA_reg, 2'b00, clkSel_reg};
			`T1CIC_OFS_GCTRL: rdByte = {1'b0, pwmB_reg, 6'h00};
			`T1CIC_OFS_CMPA:  rdByte = cmpA_reg;
			`T1CIC_OFS_CMPB:  rdByte = cmpB_reg;
			`T1CIC_OFS_TOP:   rdByte = top_reg;
			`T1CIC_OFS_MASK:  rdByte = mask_reg & `T1CIC_IRQ_MASK_BITS;
			`T1CIC_OFS_FLAGS: rdByte = flags_reg & `T1CIC_IRQ_MASK_BITS;
			`T1CIC_OFS_PLL:   rdByte = {lowSpeed_reg, 4'h0, fastSel_reg,
				pllEnableOut, pllLocked};
			default:          rdHit = 1'b0;
		endcase
	end

	always @(posedge sys_clk) begin
		if (!rstn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `T1CIC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h000000, rdByte};
			s_axi_rresp  <= rdHit ? `T1CIC_RESP_OKAY : `T1CIC_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// >>> t1cic_consts.vh
// Purpose: Register map, field positions and timing counts of the timer1 compare block
// Assumes: 32-bit AXI4-Lite word per register, 50 MHz sys_clk
// Notes:   Byte addresses, low 8 data bits used
`ifndef T1CIC_CONSTS_VH
`define T1CIC_CONSTS_VH

`define T1CIC_ADDR_W          6
`define T1CIC_OFS_COUNT       6'h00
`define T1CIC_OFS_CTRL        6'h04
`define T1CIC_OFS_GCTRL       6'h08
`define T1CIC_OFS_CMPA        6'h0C
`define T1CIC_OFS_CMPB        6'h10
`define T1CIC_OFS_TOP         6'h14
`define T1CIC_OFS_MASK        6'h18
`define T1CIC_OFS_FLAGS       6'h1C
`define T1CIC_OFS_PLL         6'h20

`define T1CIC_CTRL_CLR_TOP    7
`define T1CIC_CTRL_PWM_A      6
`define T1CIC_GCTRL_PWM_B     6
`define T1CIC_GCTRL_PRE_RST   1

`define T1CIC_BIT_CMPA        6
`define T1CIC_BIT_CMPB        5
`define T1CIC_BIT_OVF         2
`define T1CIC_IRQ_MASK_BITS   8'h64

`define T1CIC_PLL_LSM         7
`define T1CIC_PLL_FAST_SEL    2
`define T1CIC_PLL_EN          1
`define T1CIC_PLL_LOCK        0

`define T1CIC_COMPAT_CODE     4'h3
`define T1CIC_COMPAT_FAST_MAX 4'h4
`define T1CIC_PRE_W           14

`define T1CIC_CLK_MHZ         50
`define T1CIC_SETTLE_US       100
`define T1CIC_SETTLE_CYC      (`T1CIC_SETTLE_US * `T1CIC_CLK_MHZ)

`define T1CIC_RESP_OKAY       2'h0
`define T1CIC_RESP_SLVERR     2'h2

`endif

// >>> t1cic_chk.sv
// Purpose: Port assertions for t1cic_timer
// Assumes: One sys_clk domain, reset active low
// Notes:   Flags are internal, so the irq lines stand in for them
`timescale 1ns/1ns
`include "t1cic_consts.vh"
module t1cic_chk (
	// Clock and reset
	input wire		sys_clk,
	input wire		rstn,
	// Register read
	input wire [5:0]	s_axi_araddr,
	input wire		s_axi_arvalid,
	input wire		s_axi_arready,
	input wire [31:0]	s_axi_rdata,
	// Core side
	input wire		globalIrqEnable,
	input wire		vecDoneCmpB,
	input wire		irqCmpA,
	input wire		irqCmpB,
	input wire		irqOvf,
	input wire		matchA,
	input wire		matchB,
	input wire		matchTop,
	// Clock system
	input wire		pllIsSysClkPin,
	input wire		pllEnableOut,
	input wire		lowSpeedOut
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	wire rdTake = s_axi_arvalid && s_axi_arready;
	irq_gate_a: assert property (irqCmpA |-> $past(globalIrqEnable))
		else $error("irqCmpA high without global enable");
	irq_gate_b_a: assert property (irqCmpB |-> $past(globalIrqEnable))
		else $error("irqCmpB high without global enable");
	ovf_gate_a: assert property (irqOvf |-> $past(globalIrqEnable))
		else $error("irqOvf high without global enable");
	match_once_a: assert property (matchA |=> !matchA)
		else $error("matchA held for two cycles");
	// A set arriving with the vector pulse wins, so only the clean case is checked
	vec_clear_a: assert property (vecDoneCmpB && !matchB |-> ##2 !irqCmpB)
		else $error("vector did not clear B flag");
	low_speed_a: assert property (pllIsSysClkPin [*4] |-> !$rose(lowSpeedOut))
		else $error("low speed set while PLL drives system clock");
	pll_on_a: assert property (pllIsSysClkPin [*4] |-> pllEnableOut)
		else $error("PLL enable low while PLL drives system clock");
	res_irq_a: assert property (rdTake && (s_axi_araddr == `T1CIC_OFS_MASK ||
		s_axi_araddr == `T1CIC_OFS_FLAGS) |=> !s_axi_rdata[7] && !s_axi_rdata[0])
		else $error("reserved mask or flag bit reads one");
	res_pll_a: assert property (rdTake && s_axi_araddr == `T1CIC_OFS_PLL
		|=> s_axi_rdata[6:3] == 4'h0)
		else $error("reserved PLL bits read nonzero");
	cover property (matchTop);
	cover property (vecDoneCmpB && irqCmpB);
	cover property ($rose(irqOvf));
endmodule
bind t1cic_timer t1cic_chk chk (.sys_clk(sys_clk), .rstn(rstn),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.globalIrqEnable(globalIrqEnable), .vecDoneCmpB(vecDoneCmpB), .irqCmpA(irqCmpA),
	.irqCmpB(irqCmpB), .irqOvf(irqOvf), .matchA(matchA), .matchB(matchB),
	.matchTop(matchTop), .pllIsSysClkPin(pllIsSysClkPin), .pllEnableOut(pllEnableOut),
	.lowSpeedOut(lowSpeedOut));

// >>> tb_top.sv
// Purpose: Self-checking bench for t1cic_timer
// Assumes: Settle time cut to 20 cycles
// Notes:   Fast tick pulses every other system clock; the timer runs only when a test starts it
`timescale 1ns/1ns
`include "t1cic_consts.vh"
module tb_top;
	typedef struct {logic [5:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} t1cic_row_t;
	logic		sys_clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic		s_axi_rready, globalIrqEnable, vecDoneCmpB, pllLockPin, pllIsSysClkPin;
	logic		s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic		irqCmpA, irqCmpB, irqOvf, pllEnableOut, lowSpeedOut, matchA, matchB, matchTop;
	logic [5:0]	s_axi_awaddr, s_axi_araddr;
	logic [31:0]	s_axi_wdata, s_axi_rdata;
	logic [1:0]	s_axi_bresp, s_axi_rresp;
	logic [3:0]	s_axi_wstrb = 4'hF;
	logic [3:0]	clockSelectFusesPin = 4'h0;
	logic		fastClkTick = 1'b0, vecDoneCmpA = 1'b0, vecDoneOvf = 1'b0;
	int		numErrors = 0, testsRun = 0, n;
	t1cic_row_t	rows [8];

	t1cic_timer #(.SETTLE_CYCLES(20)) DUT (.sys_clk(sys_clk), .rstn(rstn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .globalIrqEnable(globalIrqEnable),
		.vecDoneCmpA(vecDoneCmpA), .vecDoneCmpB(vecDoneCmpB), .vecDoneOvf(vecDoneOvf),
		.irqCmpA(irqCmpA), .irqCmpB(irqCmpB), .irqOvf(irqOvf), .fastClkTick(fastClkTick),
		.pllLockPin(pllLockPin), .pllIsSysClkPin(pllIsSysClkPin),
		.clockSelectFusesPin(clockSelectFusesPin), .pllEnableOut(pllEnableOut),
		.lowSpeedOut(lowSpeedOut), .matchA(matchA), .matchB(matchB), .matchTop(matchTop));

	// Fast peripheral clock seen as a pulse on every second system clock
	always @(posedge sys_clk)
		fastClkTick <= !fastClkTick;

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			numErrors++;
			$display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
		logic awDone, wDone;
		awDone = 1'b0;
		wDone = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		// Each channel is released at the edge that takes it
		while (!(awDone && wDone)) begin
			@(posedge sys_clk);
			if (!awDone && s_axi_awready) begin
				awDone = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wDone && s_axi_wready) begin
				wDone = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, r);
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, e);
		chk(s_axi_rresp, r);
	endtask

	// Clear-on-top with top 2: one timer tick period is half the match spacing
	task automatic period(input logic [3:0] cs, input int exp);
		int k;
		k = 0;
		wr(`T1CIC_OFS_COUNT, 32'h00);
		wr(`T1CIC_OFS_CTRL, {24'h000000, 4'h8, cs});
		do @(posedge sys_clk); while (!matchTop);
		do begin
			tick(1);
			k++;
		end while (!matchTop);
		chk(k, exp);
		wr(`T1CIC_OFS_CTRL, 32'h00);
	endtask

	task automatic testDone;
		$display("comparisons %0d mismatches %0d", testsRun, numErrors);
		if (numErrors == 0 && testsRun > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Whole run is under 400 cycles; the 15000-cycle limit means a hang
	initial begin
		#300000;
		numErrors++;
		testDone;
	end

	initial begin
		rstn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{globalIrqEnable, vecDoneCmpB, pllLockPin, pllIsSysClkPin} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		rows[0] = '{`T1CIC_OFS_CMPA, 32'h5A, 32'h5A, 2'h0};
		rows[1] = '{`T1CIC_OFS_TOP, 32'h3C, 32'h3C, 2'h0};
		rows[2] = '{`T1CIC_OFS_MASK, 32'hFF, 32'h64, 2'h0};
		rows[3] = '{`T1CIC_OFS_FLAGS, 32'hFF, 32'h00, 2'h0};
		// Fast select refused until PLL enable already stands
		rows[4] = '{`T1CIC_OFS_PLL, 32'hFE, 32'h82, 2'h0};
		rows[5] = '{`T1CIC_OFS_PLL, 32'hFE, 32'h86, 2'h0};
		rows[6] = '{`T1CIC_OFS_PLL, 32'h00, 32'h00, 2'h0};
		rows[7] = '{6'h24, 32'h55, 32'h00, 2'h2};
		tick(3);
		rstn <= 1'b1;
		rd(`T1CIC_OFS_PLL, 32'h00);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d, rows[i].r);
			rd(rows[i].a, rows[i].e, rows[i].r);
		end
		globalIrqEnable <= 1'b1;
		wr(`T1CIC_OFS_CMPA, 32'h10);
		wr(`T1CIC_OFS_CMPB, 32'h20);
		wr(`T1CIC_OFS_MASK, 32'h64);
		wr(`T1CIC_OFS_COUNT, 32'h00);
		wr(`T1CIC_OFS_CTRL, 32'h01);
		do @(posedge sys_clk); while (!matchA);
		tick(1);
		chk(irqCmpA, 1'b0);
		tick(1);
		chk(irqCmpA, 1'b1);
		do @(posedge sys_clk); while (!matchB);
		wr(`T1CIC_OFS_CTRL, 32'h00);
		rd(`T1CIC_OFS_FLAGS, 32'h60);
		chk(irqCmpB, 1'b1);
		globalIrqEnable <= 1'b0;
		tick(2);
		chk(irqCmpB, 1'b0);
		globalIrqEnable <= 1'b1;
		wr(`T1CIC_OFS_FLAGS, 32'h40);
		rd(`T1CIC_OFS_FLAGS, 32'h20);
		vecDoneCmpB <= 1'b1;
		tick(1);
		vecDoneCmpB <= 1'b0;
		rd(`T1CIC_OFS_FLAGS, 32'h00);
		// Counter forced onto the A value while running must stay silent
		wr(`T1CIC_OFS_CTRL, 32'h01);
		wr(`T1CIC_OFS_COUNT, 32'h10);
		tick(2);
		rd(`T1CIC_OFS_FLAGS, 32'h00);
		wr(`T1CIC_OFS_COUNT, 32'hFE);
		do @(posedge sys_clk); while (!irqOvf);
		wr(`T1CIC_OFS_CTRL, 32'h00);
		rd(`T1CIC_OFS_FLAGS, 32'h04);
		vecDoneOvf <= 1'b1;
		tick(1);
		vecDoneOvf <= 1'b0;
		rd(`T1CIC_OFS_FLAGS, 32'h00);
		wr(`T1CIC_OFS_TOP, 32'h08);
		for (int m = 0; m < 3; m++) begin
			wr(`T1CIC_OFS_FLAGS, 32'h64);
			wr(`T1CIC_OFS_COUNT, 32'h00);
			wr(`T1CIC_OFS_GCTRL, m == 2 ? 32'h40 : 32'h00);
			wr(`T1CIC_OFS_CTRL, m == 1 ? 32'h81 : m == 2 ? 32'h01 : 32'h41);
			do @(posedge sys_clk); while (!matchTop);
			n = 0;
			do begin
				tick(1);
				n++;
			end while (!matchTop);
			chk(n, 9);
			chk(irqOvf, m != 1);
			chk(irqCmpA, 1'b0);
			wr(`T1CIC_OFS_CTRL, 32'h00);
		end
		wr(`T1CIC_OFS_GCTRL, 32'h00);
		pllIsSysClkPin <= 1'b1;
		tick(4);
		wr(`T1CIC_OFS_PLL, 32'h80);
		rd(`T1CIC_OFS_PLL, 32'h02);
		pllIsSysClkPin <= 1'b0;
		pllLockPin <= 1'b1;
		tick(3);
		wr(`T1CIC_OFS_PLL, 32'h02);
		rd(`T1CIC_OFS_PLL, 32'h02);
		tick(30);
		rd(`T1CIC_OFS_PLL, 32'h03);
		wr(`T1CIC_OFS_TOP, 32'h02);
		period(4'h3, 8);
		wr(`T1CIC_OFS_PLL, 32'h06);
		period(4'h1, 4);
		// Timer is stopped here, so the speed change is safe
		wr(`T1CIC_OFS_PLL, 32'h86);
		chk(lowSpeedOut, 1'b1);
		period(4'h1, 8);
		clockSelectFusesPin <= 4'h3;
		tick(3);
		period(4'h2, 8);
		period(4'h6, 4);
		chk(pllEnableOut, 1'b1);
		rstn <= 1'b0;
		tick(3);
		rstn <= 1'b1;
		rd(`T1CIC_OFS_PLL, 32'h00);
		chk(lowSpeedOut, 1'b0);
		chk(pllEnableOut, 1'b0);
		testDone;
	end
endmodule
